//--- design/uart_mode_pkg.sv
package uart_mode_pkg;
  // Notes on behaviour
  // - Transparent recognised characters enter receive queue normally.
  // - Withheld character status lost unless block error mode.
  // - Transmit field picks queue level for arbiter bid.
  // - Flow field: host, auto transmit, auto receive, both.
  // - Auto transmit: Xoff pauses, Xon resumes transmitter.
  // - Auto receive: send Xoff at twelve queued characters.
  // - After auto Xoff, send Xon at eight or fewer.
  // - Nonzero flow field blocks Xon/Xoff send commands.
  // - Flow characters always raise recognition event when enabled.
  // - Reading recognition status clears event and its bits.
  // - Address field: none, wake, doze, wake and doze.
  // - Nonzero address field makes comparators general detectors.
  // - Request to send follows commands unless automatic.
  // - Receiver control negates request on start at threshold.
  // - Receiver control reasserts request below three quarters.
  // - Masking set: status reads are live AND mask.
  // - Masking clear: status reads return raw live status.
  // - Character mode: error bits describe queue output character.
  // - Block mode: error bits OR since reset-error command.
  // - Parity codes 00, 01 use parity; 10 none.
  // - Parity code 11 selects multidrop wake-up mode.
  // - Parity type bit meaning depends on parity mode.
  // - Length field gives five to eight data bits.
  // - New mode values act on the next cycle.
  // - Interrupt mask bit four gates the recognition interrupt.
  // - Reset disables recognition and its interrupt.

  localparam logic [2:0] SEL_MODE0 = 3'h0;
  localparam logic [2:0] SEL_MODE1 = 3'h1;
  localparam logic [2:0] SEL_CHAR_RECOGNITION_EVENT_STATUS  = 3'h2;
  localparam logic [2:0] SEL_ISR   = 3'h3;

  localparam int M0_FLOW_TRANSP = 7;
  localparam int M0_ADDR_TRANSP = 6;
  localparam int M0_TRANSMIT_INTERRUPT_LEVEL_LSB   = 4;
  localparam int M0_FLOW_LSB    = 2;
  localparam int M0_ADDR_LSB    = 0;
  localparam int M1_RX_RTS      = 7;
  localparam int M1_ISR_MASKED  = 6;
  localparam int M1_BLOCK_ERR   = 5;
  localparam int M1_PAR_LSB     = 3;
  localparam int M1_PAR_TYPE    = 2;
  localparam int M1_BITS_LSB    = 0;
  localparam int REC_IRQ_BIT    = 4;

  localparam logic [7:0] MODE0_RESET = 8'h00;
  localparam logic [7:0] MODE1_RESET = 8'h00;

  localparam logic [1:0] TRANSMIT_INTERRUPT_LEVEL_EMPTY  = 2'h0;
  localparam logic [1:0] TRANSMIT_INTERRUPT_LEVEL_3Q     = 2'h1;
  localparam logic [1:0] TRANSMIT_INTERRUPT_LEVEL_HALF   = 2'h2;
  localparam logic [1:0] FLOW_HOST    = 2'h0;
  localparam logic [1:0] ADDR_NONE    = 2'h0;
  localparam logic [1:0] PAR_WAKEUP   = 2'h3;
  localparam logic [1:0] PAR_NONE     = 2'h2;

  localparam logic [4:0] QUEUE_DEPTH   = 5'h10;
  localparam logic [4:0] TX_3Q_EMPTY   = 5'h04;
  localparam logic [4:0] TX_HALF_EMPTY = 5'h08;
  localparam logic [4:0] RX_XOFF_LEVEL = 5'h0C;
  localparam logic [4:0] RX_XON_LEVEL  = 5'h08;
  localparam logic [4:0] RX_RTS_LEVEL  = 5'h0C;
  localparam int         BITS_BASE     = 5;

  typedef struct packed {
    logic       valid;
    logic       xon_match;
    logic       xoff_match;
    logic       addr_match;
    logic [2:0] status;
  } rx_event_t;

  typedef struct packed {
    logic       pop;
    logic [2:0] status;
  } pop_event_t;

  typedef struct packed {
    logic send_xon;
    logic send_xoff;
    logic rts_on;
    logic rts_off;
    logic reset_error;
    logic rec_on;
  } cmd_t;

  typedef struct packed {
    logic       parity_on;
    logic       parity_sense;
    logic       wakeup;
    logic [1:0] data_bits;
    logic       auto_wake;
    logic       auto_doze;
  } line_cfg_t;

  typedef struct packed {
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [2:0] char_recognition_event_status;
    logic       rec_enable;
    logic       tx_paused;
    logic       xoff_sent;
    logic       rts_n;
    logic       rts_auto_neg;
    logic [2:0] queued_status;
    logic [7:0] rdata;
    logic       send_xon;
    logic       send_xoff;
    logic       push;
    logic [2:0] push_status;
    logic       tx_bid;
    logic       irq;
  } state_t;

  localparam state_t STATE_RESET = '{mode0: MODE0_RESET, mode1: MODE1_RESET,
                                     rts_n: 1'b1, default: '0};
endpackage : uart_mode_pkg

//--- design/uart_channel_mode_control.sv
module uart_channel_mode_control (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    host_wr,
  input  wire logic                    host_rd,
  input  wire logic [2:0]              host_sel,
  input  wire logic [7:0]              host_wdata,
  output logic [7:0]                   host_rdata,
  input  wire uart_mode_pkg::rx_event_t rx_char,
  input  wire uart_mode_pkg::pop_event_t queue_pop,
  input  wire uart_mode_pkg::cmd_t     command,
  input  wire logic                    start_bit,
  input  wire logic [4:0]              rx_level,
  input  wire logic [4:0]              tx_level,
  input  wire logic [7:0]              interrupt_mask,
  input  wire logic [7:0]              live_status,
  output logic                         rx_push,
  output logic [2:0]                   rx_push_status,
  output logic [2:0]                   queued_status,
  output logic                         tx_bid,
  output logic                         tx_paused,
  output logic                         send_xon,
  output logic                         send_xoff,
  output logic                         request_to_send_out_n,
  output logic                         char_rec_irq,
  output uart_mode_pkg::line_cfg_t     line_cfg
);
  import uart_mode_pkg::*;

  state_t st;
  state_t next_st;

  logic [1:0] transmit_interrupt_level_f;
  logic [1:0] flow_f;
  logic [1:0] addr_f;
  logic [1:0] par_f;
  logic       flow_char;
  logic       addr_char;
  logic       withheld;
  logic [7:0] live_all;

  assign transmit_interrupt_level_f = st.mode0[M0_TRANSMIT_INTERRUPT_LEVEL_LSB +: 2];
  assign flow_f  = st.mode0[M0_FLOW_LSB +: 2];
  assign addr_f  = st.mode0[M0_ADDR_LSB +: 2];
  assign par_f   = st.mode1[M1_PAR_LSB +: 2];

  // Comparators only count while recognition is switched on after reset.
  assign flow_char = rx_char.valid && st.rec_enable && (rx_char.xon_match || rx_char.xoff_match);
  assign addr_char = rx_char.valid && st.rec_enable && rx_char.addr_match
                     && (addr_f != ADDR_NONE);
  assign withheld  = (flow_char && !st.mode0[M0_FLOW_TRANSP])
                     || (addr_char && !st.mode0[M0_ADDR_TRANSP]);

  always_comb begin
    live_all = live_status;
    live_all[REC_IRQ_BIT] = |st.char_recognition_event_status;
  end

  always_comb begin
    next_st = st;
    next_st.send_xon  = 1'b0;
    next_st.send_xoff = 1'b0;

    // Fields change the cycle after the write; a character in flight during the write still sees the old value.
    if (host_wr && host_sel == SEL_MODE0) begin
      next_st.mode0 = host_wdata;
    end
    if (host_wr && host_sel == SEL_MODE1) begin
      next_st.mode1 = host_wdata;
    end

    next_st.push        = rx_char.valid && !withheld;
    next_st.push_status = rx_char.status;

    // Error bits: character mode tracks the queue head, block mode ORs.
    if (st.mode1[M1_BLOCK_ERR]) begin
      if (command.reset_error) begin
        next_st.queued_status = 3'h0;
      end
      if (queue_pop.pop) begin
        next_st.queued_status = next_st.queued_status | queue_pop.status;
      end
      if (rx_char.valid && withheld) begin
        next_st.queued_status = next_st.queued_status | rx_char.status;
      end
    end else if (queue_pop.pop) begin
      next_st.queued_status = queue_pop.status;
    end

    unique case (transmit_interrupt_level_f)
      TRANSMIT_INTERRUPT_LEVEL_EMPTY: next_st.tx_bid = (tx_level == 5'h00);
      TRANSMIT_INTERRUPT_LEVEL_3Q:    next_st.tx_bid = (tx_level <= TX_3Q_EMPTY);
      TRANSMIT_INTERRUPT_LEVEL_HALF:  next_st.tx_bid = (tx_level <= TX_HALF_EMPTY);
      default:     next_st.tx_bid = (tx_level < QUEUE_DEPTH);
    endcase

    // Bit 0 of the flow field gates the transmitter, bit 1 watches the queue.
    if (!flow_f[0]) begin
      next_st.tx_paused = 1'b0;
    end else if (flow_char && rx_char.xoff_match) begin
      next_st.tx_paused = 1'b1;
    end else if (flow_char && rx_char.xon_match) begin
      next_st.tx_paused = 1'b0;
    end

    if (flow_f == FLOW_HOST) begin
      next_st.send_xon  = command.send_xon;
      next_st.send_xoff = command.send_xoff;
      next_st.xoff_sent = 1'b0;
    end else if (flow_f[1]) begin
      if (!st.xoff_sent && rx_level >= RX_XOFF_LEVEL) begin
        next_st.send_xoff = 1'b1;
        next_st.xoff_sent = 1'b1;
      end else if (st.xoff_sent && rx_level <= RX_XON_LEVEL) begin
        next_st.send_xon  = 1'b1;
        next_st.xoff_sent = 1'b0;
      end
    end else begin
      next_st.xoff_sent = 1'b0;
    end

    // Commands steer the pin; receiver control overrides on a start at threshold and when reasserting below it.
    if (command.rts_on) begin
      next_st.rts_n        = 1'b0;
      next_st.rts_auto_neg = 1'b0;
    end else if (command.rts_off) begin
      next_st.rts_n        = 1'b1;
      next_st.rts_auto_neg = 1'b0;
    end
    if (st.mode1[M1_RX_RTS]) begin
      if (start_bit && rx_level >= RX_RTS_LEVEL) begin
        next_st.rts_n        = 1'b1;
        next_st.rts_auto_neg = 1'b1;
      end else if (st.rts_auto_neg && rx_level < RX_RTS_LEVEL) begin
        next_st.rts_n        = 1'b0;
        next_st.rts_auto_neg = 1'b0;
      end
    end else begin
      next_st.rts_auto_neg = 1'b0;
    end

    if (command.rec_on) begin
      next_st.rec_enable = 1'b1;
    end

    // A read clears first so that an event in the same cycle survives.
    if (host_rd && host_sel == SEL_CHAR_RECOGNITION_EVENT_STATUS) begin
      next_st.char_recognition_event_status = 3'h0;
    end
    if (flow_char && rx_char.xon_match) begin
      next_st.char_recognition_event_status[0] = 1'b1;
    end
    if (flow_char && rx_char.xoff_match) begin
      next_st.char_recognition_event_status[1] = 1'b1;
    end
    if (addr_char) begin
      next_st.char_recognition_event_status[2] = 1'b1;
    end
    next_st.irq = (|next_st.char_recognition_event_status) && interrupt_mask[REC_IRQ_BIT];

    next_st.rdata = 8'h00;
    if (host_rd) begin
      unique case (host_sel)
        SEL_MODE0: next_st.rdata = st.mode0;
        SEL_MODE1: next_st.rdata = st.mode1;
        SEL_CHAR_RECOGNITION_EVENT_STATUS:  next_st.rdata = {5'h00, st.char_recognition_event_status};
        SEL_ISR: begin
          if (st.mode1[M1_ISR_MASKED]) begin
            next_st.rdata = live_all & interrupt_mask;
          end else begin
            next_st.rdata = live_all;
          end
        end
        default:   next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign host_rdata            = st.rdata;
  assign rx_push               = st.push;
  assign rx_push_status        = st.push_status;
  assign queued_status         = st.queued_status;
  assign tx_bid                = st.tx_bid;
  assign tx_paused             = st.tx_paused;
  assign send_xon              = st.send_xon;
  assign send_xoff             = st.send_xoff;
  assign request_to_send_out_n = st.rts_n;
  assign char_rec_irq          = st.irq;
  // Parity sense means odd, forced value or address polarity by mode.
  assign line_cfg.parity_on    = (par_f < PAR_NONE);
  assign line_cfg.parity_sense = st.mode1[M1_PAR_TYPE];
  assign line_cfg.wakeup       = (par_f == PAR_WAKEUP);
  assign line_cfg.data_bits    = st.mode1[M1_BITS_LSB +: 2];
  assign line_cfg.auto_wake    = addr_f[0];
  assign line_cfg.auto_doze    = addr_f[1];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  transparent_push_a: assert property (
    flow_char && st.mode0[M0_FLOW_TRANSP] |=> rx_push && rx_push_status == $past(rx_char.status))
    else $error("Transparent flow character was not pushed.");

  withheld_status_a: assert property (
    rx_char.valid && withheld && !st.mode1[M1_BLOCK_ERR] && !queue_pop.pop
    && !(host_wr && host_sel == SEL_MODE1) |=> !rx_push && $stable(queued_status))
    else $error("Withheld character status leaked in character mode.");

  tx_bid_empty_a: assert property (
    transmit_interrupt_level_f == TRANSMIT_INTERRUPT_LEVEL_EMPTY && tx_level == 5'h01 |=> !tx_bid)
    else $error("Transmit bid raised above empty level.");

  auto_xoff_a: assert property (
    flow_f[1] && !st.xoff_sent && rx_level >= RX_XOFF_LEVEL |=> send_xoff ##1 !send_xoff)
    else $error("Automatic Xoff not sent once.");

  auto_xon_a: assert property (
    flow_f[1] && st.xoff_sent && rx_level <= RX_XON_LEVEL |=> send_xon && !st.xoff_sent)
    else $error("Automatic Xon not sent on drain.");

  cmd_blocked_a: assert property (
    flow_f == 2'h1 && command.send_xoff |=> !send_xoff)
    else $error("Xoff command acted outside host mode.");

  xoff_pause_a: assert property (
    flow_f[0] && flow_char && rx_char.xoff_match && !rx_char.xon_match
    && !(host_wr && host_sel == SEL_MODE0) |=> tx_paused)
    else $error("Transmitter did not pause on Xoff.");

  read_clear_a: assert property (
    host_rd && host_sel == SEL_CHAR_RECOGNITION_EVENT_STATUS && !rx_char.valid |=> st.char_recognition_event_status == 3'h0 && !char_rec_irq)
    else $error("Recognition status survived its read.");

  rts_negate_a: assert property (
    st.mode1[M1_RX_RTS] && start_bit && rx_level >= RX_RTS_LEVEL
    |=> request_to_send_out_n ##1 (request_to_send_out_n || $past(rx_level) < RX_RTS_LEVEL
                                   || $past(command.rts_on)))
    else $error("Request to send stayed asserted at threshold.");

  isr_masked_a: assert property (
    host_rd && host_sel == SEL_ISR && st.mode1[M1_ISR_MASKED]
    |=> host_rdata == ($past(live_all) & $past(interrupt_mask)))
    else $error("Masked status read returned unmasked bits.");

  rec_irq_a: assert property (
    flow_char && interrupt_mask[REC_IRQ_BIT] |=> char_rec_irq)
    else $error("Recognition interrupt not raised.");

  // The checks below pin down each mode field except parity type and length so a miswired bit cannot hide behind another.
  strip_push_a: assert property (
    rx_char.valid && withheld
    |=> !rx_push)
    else $error("Withheld character was pushed.");

  tx_bid_3q_a: assert property (
    transmit_interrupt_level_f == TRANSMIT_INTERRUPT_LEVEL_3Q && tx_level == 5'h05
    |=> !tx_bid)
    else $error("Transmit bid raised above three-quarters empty level.");

  tx_bid_notfull_a: assert property (
    transmit_interrupt_level_f == 2'h3 && tx_level == 5'h0F
    |=> tx_bid)
    else $error("Transmit bid missing while queue not full.");

  tx_free_a: assert property (
    !flow_f[0]
    |=> !tx_paused)
    else $error("Transmitter paused without transmit flow control.");

  xon_resume_a: assert property (
    flow_f[0] && flow_char && rx_char.xon_match && !rx_char.xoff_match
    && !(host_wr && host_sel == SEL_MODE0) |=> !tx_paused)
    else $error("Transmitter did not resume on Xon.");

  host_xoff_a: assert property (
    flow_f == FLOW_HOST && command.send_xoff
    |=> send_xoff)
    else $error("Host mode Xoff command was lost.");

  cmd_xon_blocked_a: assert property (
    flow_f != FLOW_HOST && command.send_xon && !(flow_f[1] && st.xoff_sent)
    |=> !send_xon)
    else $error("Xon command acted outside host mode.");

  addr_off_a: assert property (
    addr_f == ADDR_NONE && !st.char_recognition_event_status[2]
    |=> !st.char_recognition_event_status[2])
    else $error("Address event raised with recognition off.");

  addr_detect_a: assert property (
    addr_char
    |=> st.char_recognition_event_status[2])
    else $error("Address character not detected.");

  rts_cmd_on_a: assert property (
    command.rts_on && !st.mode1[M1_RX_RTS]
    |=> !request_to_send_out_n)
    else $error("Request to send command did not assert the pin.");

  rts_cmd_off_a: assert property (
    command.rts_off && !command.rts_on && !st.rts_auto_neg
    |=> request_to_send_out_n)
    else $error("Request to send command did not negate the pin.");

  rts_reassert_a: assert property (
    st.mode1[M1_RX_RTS] && st.rts_auto_neg && rx_level < RX_RTS_LEVEL
    |=> !request_to_send_out_n)
    else $error("Request to send not reasserted below threshold.");

  isr_raw_a: assert property (
    host_rd && host_sel == SEL_ISR && !st.mode1[M1_ISR_MASKED]
    |=> host_rdata == $past(live_all))
    else $error("Unmasked status read was altered.");

  char_err_a: assert property (
    !st.mode1[M1_BLOCK_ERR] && queue_pop.pop
    |=> queued_status == $past(queue_pop.status))
    else $error("Character mode status does not follow queue head.");

  block_keep_a: assert property (
    st.mode1[M1_BLOCK_ERR] && !command.reset_error
    |=> (queued_status & $past(queued_status)) == $past(queued_status))
    else $error("Block mode status bit dropped without reset.");

  block_clear_a: assert property (
    st.mode1[M1_BLOCK_ERR] && command.reset_error && !queue_pop.pop && !rx_char.valid
    |=> queued_status == 3'h0)
    else $error("Reset error command did not clear status.");

  parity_cfg_a: assert property (
    line_cfg.parity_on == (par_f == 2'h0 || par_f == 2'h1))
    else $error("Parity enable decoded wrongly.");

  wakeup_cfg_a: assert property (
    line_cfg.wakeup == (par_f == 2'h3))
    else $error("Wake-up mode decoded wrongly.");

  rec_off_a: assert property (
    !st.rec_enable
    |-> !flow_char && !addr_char)
    else $error("Recognition active before it was enabled.");

  irq_masked_a: assert property (
    !interrupt_mask[REC_IRQ_BIT]
    |=> !char_rec_irq)
    else $error("Recognition interrupt raised while masked.");

  rdata_idle_a: assert property (
    !host_rd
    |=> host_rdata == 8'h00)
    else $error("Read data shown without a read.");

  mode_read_a: assert property (
    host_rd && host_sel == SEL_MODE0
    |=> host_rdata == $past(st.mode0))
    else $error("Mode zero read back wrong value.");

  cover_strip_c:    cover property (flow_char && !st.mode0[M0_FLOW_TRANSP] ##1 !rx_push);
  cover_xoff_xon_c: cover property (send_xoff ##[1:200] send_xon);
  cover_rts_c:      cover property (st.rts_auto_neg ##[1:200] !request_to_send_out_n);
  cover_block_c:    cover property (st.mode1[M1_BLOCK_ERR] && queue_pop.pop && |queue_pop.status);
endmodule : uart_channel_mode_control

//--- test/remote_serial_peer.sv
module remote_serial_peer (
  input  wire logic                 clk,
  output uart_mode_pkg::rx_event_t  rx_char,
  output uart_mode_pkg::pop_event_t queue_pop,
  output logic                      start_bit,
  output logic [4:0]                rx_level
);
  timeunit 1ns;
  timeprecision 1ns;
  import uart_mode_pkg::*;

  initial begin
    rx_char = '0;
    queue_pop = '0;
    start_bit = 1'b0;
    rx_level = 5'h00;
  end

  // Between characters the qualifiers show the inverse of the last value, so a design
  // that looks at matches or status without valid is caught.
  task automatic send_char(input rx_event_t ev);
    @(posedge clk);
    rx_char <= ev;
    @(posedge clk);
    rx_char <= {1'b0, ~ev[5:0]};
  endtask : send_char

  task automatic pop_char(input logic [2:0] st);
    @(posedge clk);
    queue_pop <= {1'b1, st};
    @(posedge clk);
    queue_pop <= {1'b0, ~st};
  endtask : pop_char

  task automatic start_char(input logic [4:0] lvl);
    @(posedge clk);
    rx_level <= lvl;
    start_bit <= 1'b1;
    @(posedge clk);
    start_bit <= 1'b0;
  endtask : start_char

  task automatic set_level(input logic [4:0] lvl);
    @(posedge clk);
    rx_level <= lvl;
  endtask : set_level
endmodule : remote_serial_peer

//--- test/test_uart_channel_mode_control.sv
module test_uart_channel_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_mode_pkg::*;
  localparam rx_event_t XON_EV  = 7'h60;
  localparam rx_event_t XOFF_EV = 7'h50;
  localparam rx_event_t ADDR_EV = 7'h48;
  logic       clk, rst_b, host_wr, host_rd, start_bit, rx_push, tx_bid, tx_paused;
  logic       send_xon, send_xoff, request_to_send_out_n, char_rec_irq;
  logic [2:0] host_sel, rx_push_status, queued_status;
  logic [4:0] rx_level, tx_level;
  logic [7:0] host_wdata, host_rdata, interrupt_mask, live_status, d;
  rx_event_t  rx_char;
  pop_event_t queue_pop;
  cmd_t       command;
  line_cfg_t  line_cfg;
  int         n_fail, check_count, n_xon, n_xoff, b;

  uart_channel_mode_control dut (.clk(clk), .rst_b(rst_b), .host_wr(host_wr),
    .host_rd(host_rd), .host_sel(host_sel), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .rx_char(rx_char), .queue_pop(queue_pop), .command(command),
    .start_bit(start_bit), .rx_level(rx_level), .tx_level(tx_level),
    .interrupt_mask(interrupt_mask), .live_status(live_status), .rx_push(rx_push),
    .rx_push_status(rx_push_status), .queued_status(queued_status), .tx_bid(tx_bid),
    .tx_paused(tx_paused), .send_xon(send_xon), .send_xoff(send_xoff),
    .request_to_send_out_n(request_to_send_out_n), .char_rec_irq(char_rec_irq),
    .line_cfg(line_cfg));
  remote_serial_peer peer (.clk(clk), .rx_char(rx_char), .queue_pop(queue_pop),
    .start_bit(start_bit), .rx_level(rx_level));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (send_xon === 1'b1) n_xon++;
    if (send_xoff === 1'b1) n_xoff++;
  end

  task automatic give_verdict;
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] sel, input logic [7:0] data);
    @(posedge clk);
    host_wr <= 1'b1;
    host_sel <= sel;
    host_wdata <= data;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] sel);
    @(posedge clk);
    host_rd <= 1'b1;
    host_sel <= sel;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
  endtask : rd

  task automatic issue(input cmd_t c);
    @(posedge clk);
    command <= c;
    @(posedge clk);
    command <= '0;
  endtask : issue

  task automatic test_regs;
    rd(SEL_MODE1); cmp(d, MODE1_RESET);
    wr(SEL_MODE0, 8'hA5); wr(SEL_MODE1, 8'h5A); wr(3'h7, 8'hFF);
    rd(SEL_MODE0); cmp(d, 8'hA5);
    rd(SEL_MODE1); cmp(d, 8'h5A);
    rd(3'h7); cmp(d, 8'h00);
  endtask : test_regs

  task automatic test_line_cfg;
    for (int c = 0; c < 4; c++) begin
      wr(SEL_MODE1, {3'h0, 2'(c), 1'b1, 2'(c)});
      #1;
      cmp(8'(line_cfg), {1'b0, c < 2, 1'b1, c == 3, 2'(c), 2'h2});
    end
    wr(SEL_MODE0, 8'h03); #1; cmp(8'(line_cfg[1:0]), 8'h03);
  endtask : test_line_cfg

  task automatic test_tx_bid;
    logic [4:0] thr [4] = '{5'h00, 5'h04, 5'h08, 5'h0F};
    for (int c = 0; c < 4; c++) begin
      wr(SEL_MODE0, {2'h0, 2'(c), 4'h0});
      @(posedge clk); tx_level <= thr[c]; tick(2); cmp(8'(tx_bid), 8'h01);
      @(posedge clk); tx_level <= thr[c] + 5'h01; tick(2); cmp(8'(tx_bid), 8'h00);
    end
  endtask : test_tx_bid

  task automatic test_recog;
    wr(SEL_MODE0, 8'h01); wr(SEL_MODE1, 8'h00);
    @(posedge clk); interrupt_mask <= 8'hF0; live_status <= 8'hA5;
    peer.send_char(XON_EV); tick(1); cmp(8'(char_rec_irq), 8'h00);
    issue(6'h01);
    peer.send_char(XOFF_EV); tick(1); cmp(8'(char_rec_irq), 8'h01);
    rd(SEL_ISR); cmp(d, 8'hB5);
    wr(SEL_MODE1, 8'h40); rd(SEL_ISR); cmp(d, 8'hB0);
    rd(SEL_CHAR_RECOGNITION_EVENT_STATUS); cmp(d, 8'h02);
    cmp(8'(char_rec_irq), 8'h00);
    rd(SEL_CHAR_RECOGNITION_EVENT_STATUS); cmp(d, 8'h00);
    @(posedge clk); interrupt_mask <= 8'h00;
    peer.send_char(ADDR_EV); tick(1); cmp(8'(char_rec_irq), 8'h00);
    rd(SEL_CHAR_RECOGNITION_EVENT_STATUS); cmp(d, 8'h04);
  endtask : test_recog

  task automatic test_transp;
    wr(SEL_MODE0, 8'hC1);
    peer.send_char(XON_EV | 7'h02); #1; cmp({rx_push, rx_push_status}, 8'h0A);
    peer.send_char(ADDR_EV | 7'h05); #1; cmp({rx_push, rx_push_status}, 8'h0D);
    wr(SEL_MODE0, 8'h01);
    peer.send_char(XON_EV | 7'h02); #1; cmp(8'(rx_push), 8'h00);
  endtask : test_transp

  task automatic test_errors;
    wr(SEL_MODE1, 8'h00);
    peer.pop_char(3'h1); tick(1); cmp(8'(queued_status), 8'h01);
    peer.pop_char(3'h4); tick(1); cmp(8'(queued_status), 8'h04);
    wr(SEL_MODE1, 8'h20); issue(6'h02); tick(1); cmp(8'(queued_status), 8'h00);
    peer.pop_char(3'h1); peer.pop_char(3'h4); tick(1); cmp(8'(queued_status), 8'h05);
    peer.send_char(XOFF_EV | 7'h02); tick(1); cmp(8'(queued_status), 8'h07);
  endtask : test_errors

  task automatic test_flow;
    wr(SEL_MODE0, 8'h04);
    peer.send_char(XOFF_EV); tick(1); cmp(8'(tx_paused), 8'h01);
    peer.send_char(XON_EV); tick(1); cmp(8'(tx_paused), 8'h00);
    b = n_xon; issue(6'h20); tick(2); cmp(8'(n_xon - b), 8'h00);
    wr(SEL_MODE0, 8'h08); b = n_xoff;
    peer.send_char(XOFF_EV); tick(1); cmp(8'(tx_paused), 8'h00);
    peer.set_level(5'h0B); tick(2); cmp(8'(n_xoff - b), 8'h00);
    peer.set_level(5'h0C); tick(3); cmp(8'(n_xoff - b), 8'h01);
    b = n_xon; peer.set_level(5'h09); tick(3); cmp(8'(n_xon - b), 8'h00);
    peer.set_level(5'h08); tick(3); cmp(8'(n_xon - b), 8'h01);
    wr(SEL_MODE0, 8'h00); b = n_xoff;
    issue(6'h10); tick(2); cmp(8'(n_xoff - b), 8'h01);
    peer.set_level(5'h00);
  endtask : test_flow

  task automatic test_rts;
    wr(SEL_MODE1, 8'h00); cmp(8'(request_to_send_out_n), 8'h01);
    issue(6'h08); tick(1); cmp(8'(request_to_send_out_n), 8'h00);
    issue(6'h04); tick(1); cmp(8'(request_to_send_out_n), 8'h01);
    issue(6'h08); wr(SEL_MODE1, 8'h80);
    peer.start_char(5'h0B); tick(1); cmp(8'(request_to_send_out_n), 8'h00);
    peer.start_char(5'h0C); tick(1); cmp(8'(request_to_send_out_n), 8'h01);
    peer.set_level(5'h0B); tick(2); cmp(8'(request_to_send_out_n), 8'h00);
  endtask : test_rts

  initial begin
    rst_b = 1'b0; host_wr = 1'b0; host_rd = 1'b0; host_sel = 3'h0; host_wdata = 8'h00;
    command = '0; tx_level = 5'h00; interrupt_mask = 8'h00; live_status = 8'h00;
    n_fail = 0; check_count = 0; n_xon = 0; n_xoff = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(SEL_MODE0); cmp(d, MODE0_RESET);
    test_regs(); test_line_cfg(); test_tx_bid(); test_recog();
    test_transp(); test_errors(); test_flow(); test_rts();
    give_verdict();
  end

  // A hung sequence is cut short here and counted as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule : test_uart_channel_mode_control
